// *** logic/jlmd_core.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "jlmd_params.svh"

module jlmd_core (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               instr_valid,
  input  wire logic [15:0]        instr_word,
  input  wire logic [3:0]         mem_rdata,
  output logic [6:0]              mem_addr,
  output logic                    instr_known,
  output jlmd_pkg::jlmd_state_t   core_state
);

  jlmd_pkg::jlmd_state_t state_ff;
  jlmd_pkg::jlmd_state_t nxt_state;

  wire logic [4:0]  opc        = instr_word[`JLMD_OPC_MSB:`JLMD_OPC_LSB];
  wire logic [8:0]  pre        = instr_word[`JLMD_OPC_MSB:`JLMD_PRE_LSB];
  wire logic [10:0] target     = instr_word[10:0];
  wire logic [10:0] pc_next    = state_ff.pc + `JLMD_PC_STEP;
  wire logic        acc_zero   = (state_ff.accumulator == 4'h0);

  wire logic is_jmp_alw  = (opc == `JLMD_OP_JUMP_ALWAYS);
  wire logic is_jmp_cclr = (opc == `JLMD_OP_JUMP_CARRY_CLEAR);
  wire logic is_jmp_nz   = (opc == `JLMD_OP_JUMP_ACC_NONZERO);
  wire logic is_jmp_z    = (opc == `JLMD_OP_JUMP_ACC_IS_ZERO);
  wire logic is_disp_on  = (instr_word == `JLMD_WORD_DISPLAY_ON);
  wire logic is_disp_off = (instr_word == `JLMD_WORD_DISPLAY_OFF);
  wire logic is_mem_acc  = (pre == `JLMD_PRE_MEM_TO_ACC);
  wire logic is_mem_cf   = (pre == `JLMD_PRE_MEM_TO_CARRY);

  jlmd_pkg::jlmd_op_t op;
  assign op = is_jmp_alw  ? jlmd_pkg::JLMD_OP_JMP_ALW :
              is_jmp_cclr ? jlmd_pkg::JLMD_OP_JMP_CCLR :
              is_jmp_nz   ? jlmd_pkg::JLMD_OP_JMP_NZ :
              is_jmp_z    ? jlmd_pkg::JLMD_OP_JMP_Z :
              is_disp_on  ? jlmd_pkg::JLMD_OP_DISP_ON :
              is_disp_off ? jlmd_pkg::JLMD_OP_DISP_OFF :
              is_mem_acc  ? jlmd_pkg::JLMD_OP_MEM_ACC :
              is_mem_cf   ? jlmd_pkg::JLMD_OP_MEM_CARRY :
                            jlmd_pkg::JLMD_OP_NONE;

  // group decodes, read only by the checks below; they follow the same priority as op
  wire logic any_jump    = (op == jlmd_pkg::JLMD_OP_JMP_ALW)
                         | (op == jlmd_pkg::JLMD_OP_JMP_CCLR)
                         | (op == jlmd_pkg::JLMD_OP_JMP_NZ)
                         | (op == jlmd_pkg::JLMD_OP_JMP_Z);
  wire logic any_display = (op == jlmd_pkg::JLMD_OP_DISP_ON)
                         | (op == jlmd_pkg::JLMD_OP_DISP_OFF);
  wire logic op_mem_acc  = (op == jlmd_pkg::JLMD_OP_MEM_ACC);
  wire logic op_mem_cf   = (op == jlmd_pkg::JLMD_OP_MEM_CARRY);
  wire logic op_unknown  = (op == jlmd_pkg::JLMD_OP_NONE);

  // jump condition per opcode; the plain jump is always taken
  wire logic take_jump = is_jmp_alw
                       | (is_jmp_cclr & ~state_ff.carry_flag)
                       | (is_jmp_nz & ~acc_zero)
                       | (is_jmp_z & acc_zero);

  // the memory read is combinational from the address field, so the load closes in the same cycle
  assign mem_addr    = instr_word[6:0];
  assign instr_known = instr_valid & (op != jlmd_pkg::JLMD_OP_NONE);
  assign core_state  = state_ff;

  always_comb begin
    nxt_state = state_ff;
    if (instr_valid) begin
      // words outside this decoder still step the counter so the core keeps fetching
      nxt_state.pc = take_jump ? target : pc_next;
      case (op)
        jlmd_pkg::JLMD_OP_DISP_ON: begin
          nxt_state.display_en = 1'b1;
        end
        jlmd_pkg::JLMD_OP_DISP_OFF: begin
          nxt_state.display_en = 1'b0;
        end
        jlmd_pkg::JLMD_OP_MEM_ACC: begin
          nxt_state.accumulator = mem_rdata;
          nxt_state.zero_flag   = (mem_rdata == 4'h0);
        end
        jlmd_pkg::JLMD_OP_MEM_CARRY: begin
          nxt_state.carry_flag = mem_rdata[0];
        end
        default: begin
          nxt_state.display_en = state_ff.display_en;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // reset values are a local choice; software must not rely on the flags before a load
      state_ff <= '{pc:          `JLMD_RST_PC,
                    accumulator: `JLMD_RST_ACC,
                    carry_flag:  `JLMD_RST_FLAG,
                    zero_flag:   `JLMD_RST_FLAG,
                    display_en:  `JLMD_RST_FLAG};
    end else begin
      state_ff <= nxt_state;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // program counter per jump kind
  a_jump_always_pc: assert property (instr_valid && is_jmp_alw |=> state_ff.pc == $past(target))
    else $error("plain jump did not load target");

  a_carry_clear_jump: assert property (instr_valid && is_jmp_cclr |=>
      state_ff.pc == ($past(state_ff.carry_flag) ? $past(pc_next) : $past(target)))
    else $error("carry clear jump went wrong way");

  a_nonzero_jump: assert property (instr_valid && is_jmp_nz |=>
      state_ff.pc == (($past(state_ff.accumulator) != 4'h0) ? $past(target) : $past(pc_next)))
    else $error("nonzero jump went wrong way");

  a_zero_jump: assert property (instr_valid && is_jmp_z |=>
      state_ff.pc == (($past(state_ff.accumulator) == 4'h0) ? $past(target) : $past(pc_next)))
    else $error("zero jump went wrong way");

  // jumps touch nothing but the program counter
  a_jump_keeps_data: assert property (instr_valid && any_jump |=>
      $stable(state_ff.accumulator) && $stable(state_ff.carry_flag)
      && $stable(state_ff.zero_flag) && $stable(state_ff.display_en))
    else $error("jump changed data state");

  // the step is recomputed here from the old counter, not taken from pc_next
  a_pc_step_value: assert property (instr_valid && !take_jump |=>
      state_ff.pc == $past(state_ff.pc) + 11'h001)
    else $error("untaken jump did not step by one");

  a_pc_wraps_step: assert property (instr_valid && !take_jump && state_ff.pc == 11'h7FF |=>
      state_ff.pc == 11'h000)
    else $error("program counter did not wrap");

  // display commands
  a_display_on_cmd: assert property (instr_valid && is_disp_on |=> state_ff.display_en)
    else $error("display not enabled");

  a_display_off_cmd: assert property (instr_valid && is_disp_off |=> !state_ff.display_en)
    else $error("display not disabled");

  a_display_keeps_data: assert property (instr_valid && any_display |=>
      $stable(state_ff.accumulator) && $stable(state_ff.carry_flag)
      && $stable(state_ff.zero_flag) && state_ff.pc == $past(pc_next))
    else $error("display command changed data state");

  a_display_source: assert property (!(instr_valid && any_display) |=>
      $stable(state_ff.display_en))
    else $error("display enable moved without command");

  // memory loads
  a_mem_addr_field: assert property (mem_addr == instr_word[6:0])
    else $error("memory address not from word");

  a_mem_acc_load: assert property (instr_valid && is_mem_acc |=>
      state_ff.accumulator == $past(mem_rdata) && state_ff.zero_flag == ($past(mem_rdata) == 4'h0)
      && $stable(state_ff.carry_flag))
    else $error("memory to accumulator load wrong");

  a_mem_acc_step: assert property (instr_valid && op_mem_acc |=>
      state_ff.pc == $past(pc_next) && $stable(state_ff.display_en))
    else $error("memory to accumulator load disturbed pc");

  a_mem_carry_load: assert property (instr_valid && is_mem_cf |=>
      state_ff.carry_flag == $past(mem_rdata[0]) && $stable(state_ff.accumulator) && $stable(state_ff.zero_flag))
    else $error("memory bit to carry load wrong");

  a_mem_carry_step: assert property (instr_valid && op_mem_cf |=>
      state_ff.pc == $past(pc_next) && $stable(state_ff.display_en))
    else $error("memory bit to carry load disturbed pc");

  // each data field has exactly one writer
  a_acc_source: assert property (!(instr_valid && op_mem_acc) |=>
      $stable(state_ff.accumulator))
    else $error("accumulator moved without load");

  a_zero_source: assert property (!(instr_valid && op_mem_acc) |=>
      $stable(state_ff.zero_flag))
    else $error("zero flag moved without load");

  a_carry_source: assert property (!(instr_valid && op_mem_cf) |=>
      $stable(state_ff.carry_flag))
    else $error("carry flag moved without load");

  // words outside the decoder only step the counter
  a_unknown_steps: assert property (instr_valid && op_unknown |=>
      state_ff.pc == $past(pc_next) && $stable(state_ff.accumulator) && $stable(state_ff.carry_flag)
      && $stable(state_ff.zero_flag) && $stable(state_ff.display_en))
    else $error("unknown word changed data state");

  // idle and reset
  a_idle_holds_pc: assert property (!instr_valid |=> $stable(state_ff.pc))
    else $error("program counter moved without instruction");

  a_idle_holds_state: assert property (!instr_valid |=> $stable(state_ff))
    else $error("state moved without instruction");

  a_known_low_idle: assert property (!instr_valid |-> !instr_known)
    else $error("decode flagged without valid");

  // reset has to be watched while it is low, so this one is never disabled
  a_reset_clears: assert property (disable iff (1'b0) !rst_n |=> state_ff == '0)
    else $error("reset did not clear state");

  c_taken_nz: cover property (instr_valid && is_jmp_nz && !acc_zero);

  c_untaken_cclr: cover property (instr_valid && is_jmp_cclr && state_ff.carry_flag);

  c_display_toggle: cover property (instr_valid && is_disp_on ##1 instr_valid && is_disp_off);

  c_load_then_jz: cover property (instr_valid && is_mem_acc ##1 instr_valid && is_jmp_z);

  c_pc_wrap: cover property (instr_valid && !take_jump && state_ff.pc == 11'h7FF);

endmodule

`default_nettype wire

// *** logic/jlmd_params.svh ***
// Operation
// - an unconditional jump loads program counter bits 10 to 0 with its 11-bit target in one machine cycle.
// - jump on carry clear loads the target when the carry flag is 0, else the program counter steps by one.
// - jump on accumulator nonzero loads the target when the accumulator is nonzero, else the counter steps.
// - jump on accumulator zero loads the target when the accumulator is zero, else the counter steps.
// - the display enable command turns the display driver outputs on within one machine cycle.
// - the display disable command turns the display driver outputs off within one machine cycle.
// - a memory to accumulator move loads the addressed nibble and updates only the zero flag from it.
// - a memory bit to carry move loads bit 0 of the addressed nibble into the carry flag and nothing else.
`ifndef JLMD_PARAMS_SVH
`define JLMD_PARAMS_SVH

`define JLMD_OP_JUMP_ALWAYS      5'h0E
`define JLMD_OP_JUMP_CARRY_CLEAR 5'h1A
`define JLMD_OP_JUMP_ACC_NONZERO 5'h18
`define JLMD_OP_JUMP_ACC_IS_ZERO 5'h1C
`define JLMD_WORD_DISPLAY_ON     16'h0400
`define JLMD_WORD_DISPLAY_OFF    16'h0500
`define JLMD_PRE_MEM_TO_ACC      9'h09D
`define JLMD_PRE_MEM_TO_CARRY    9'h0B0
`define JLMD_OPC_MSB             15
`define JLMD_OPC_LSB             11
`define JLMD_PRE_LSB             7
`define JLMD_RST_PC              11'h000
`define JLMD_RST_ACC             4'h0
`define JLMD_RST_FLAG            1'h0
`define JLMD_PC_STEP             11'h001

`endif

// *** logic/jlmd_pkg.sv ***
`default_nettype none
package jlmd_pkg;

  typedef enum logic [3:0] {
    JLMD_OP_NONE      = 4'b0000,
    JLMD_OP_JMP_ALW   = 4'b0001,
    JLMD_OP_JMP_CCLR  = 4'b0010,
    JLMD_OP_JMP_NZ    = 4'b0011,
    JLMD_OP_JMP_Z     = 4'b0100,
    JLMD_OP_DISP_ON   = 4'b0101,
    JLMD_OP_DISP_OFF  = 4'b0110,
    JLMD_OP_MEM_ACC   = 4'b0111,
    JLMD_OP_MEM_CARRY = 4'b1000
  } jlmd_op_t;

  typedef struct packed {
    logic [10:0] pc;
    logic [3:0]  accumulator;
    logic        carry_flag;
    logic        zero_flag;
    logic        display_en;
  } jlmd_state_t;

endpackage
`default_nettype wire

// *** tb/jlmd_core_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module jlmd_core_tb;
  typedef struct packed {
    logic [15:0] w;
    logic [3:0]  r;
    logic [16:0] s;
  } jlmd_row_t;
  logic                  clk = 1'h0;
  logic                  rst_n = 1'h0;
  logic                  instr_valid = 1'h0;
  logic [15:0]           instr_word = 16'h0000;
  logic [3:0]            mem_rdata = 4'h0;
  logic [6:0]            mem_addr;
  logic                  instr_known;
  jlmd_pkg::jlmd_state_t core_state;
  int                    errors = 0;
  int                    checks_done = 0;
  // state after each row: pc, accumulator, then carry, zero, display
  jlmd_row_t rows [13] = '{
    '{16'h7123, 4'h0, {11'h123, 4'h0, 3'h0}},
    '{16'h4E85, 4'h0, {11'h124, 4'h0, 3'h2}},
    '{16'hD2AA, 4'h0, {11'h2AA, 4'h0, 3'h2}},
    '{16'h5805, 4'hF, {11'h2AB, 4'h0, 3'h6}},
    '{16'hD111, 4'h0, {11'h2AC, 4'h0, 3'h6}},
    '{16'hE155, 4'h0, {11'h155, 4'h0, 3'h6}},
    '{16'hC255, 4'h0, {11'h156, 4'h0, 3'h6}},
    '{16'h4E83, 4'h6, {11'h157, 4'h6, 3'h4}},
    '{16'hC7FF, 4'h0, {11'h7FF, 4'h6, 3'h4}},
    '{16'hE100, 4'h0, {11'h000, 4'h6, 3'h4}},  // pc wraps
    '{16'h0400, 4'h0, {11'h001, 4'h6, 3'h5}},
    '{16'h5800, 4'hE, {11'h002, 4'h6, 3'h1}},
    '{16'h0500, 4'h0, {11'h003, 4'h6, 3'h0}}
  };
  jlmd_core i_dut (
    .clk         (clk),
    .rst_n       (rst_n),
    .instr_valid (instr_valid),
    .instr_word  (instr_word),
    .mem_rdata   (mem_rdata),
    .mem_addr    (mem_addr),
    .instr_known (instr_known),
    .core_state  (core_state)
  );
  always #5 clk = ~clk;
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // inputs are set 1 ns after an edge, the answer is read 1 ns after the next
  task automatic run(input logic [15:0] w, input logic [3:0] r, input logic k);
    instr_valid = 1'h1;
    instr_word = w;
    mem_rdata = r;
    #1;
    check(17'(instr_known), 17'(k));
    check(17'(mem_addr), 17'(w[6:0]));
    @(posedge clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #5000;
    errors++;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'h1;
    check(core_state, 17'h00000);
    foreach (rows[i]) begin
      run(rows[i].w, rows[i].r, 1'h1);
      check(core_state, rows[i].s);
    end
    // idle cycle: a jump word without valid must not move anything
    instr_valid = 1'h0;
    instr_word = 16'h7123;
    #1;
    check(17'(instr_known), 17'h00000);
    @(posedge clk);
    #1;
    check(core_state, {11'h003, 4'h6, 3'h0});
    run(16'hFFFF, 4'h5, 1'h0);
    check(core_state, {11'h004, 4'h6, 3'h0});
    run(16'h0400, 4'h0, 1'h1);
    check(core_state, {11'h005, 4'h6, 3'h1});
    // reset wins over a valid instruction held on the bus
    rst_n = 1'h0;
    @(posedge clk);
    #1;
    check(core_state, 17'h00000);
    rst_n = 1'h1;
    instr_valid = 1'h0;
    @(posedge clk);
    #1;
    finish_test;
  end
endmodule
`default_nettype wire
